//--- dv/dio_bus_master.sv
// Bus master model that presents address and modifier cycles to the decoder.
// Assumes the decoder takes a cycle at the rising edge where valid is high.
`timescale 1ns/1ps
`default_nettype none
module dio_bus_master (
	input  wire logic                    clk,
	output var  dio_cfg_pkg::bus_cycle_s bus_cycle
);
	import dio_cfg_pkg::*;
	logic busy = 1'b0;
	initial bus_cycle = '0;
	// Idle lines keep toggling, but the first idle edge after an access repeats its address and modifier with valid low.
	always @(posedge clk) begin
		if (!busy) begin
			bus_cycle.addr <= ~bus_cycle.addr;
			bus_cycle.am <= ~bus_cycle.am;
			bus_cycle.valid <= 1'b0;
		end
	end
	task automatic access(input logic [23:0] a, input logic [5:0] m);
		busy = 1'b1;
		@(posedge clk);
		bus_cycle <= '{addr: a, am: m, valid: 1'b1};
		@(posedge clk);
		bus_cycle <= '{addr: ~a, am: ~m, valid: 1'b0};
		#1 busy = 1'b0;
	endtask
endmodule // dio_bus_master
`default_nettype wire

//--- dv/tb_isolated_dio_vme_slave_config.sv
// Self-checking bench for the configuration block: decode, modifiers, levels, debounce.
// Assumes the bus master model and shortened debounce counts of 4, 8, 12 and 16.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	$display("ERROR %s expected %h seen %h", nm, e, g); fails++; end end
module tb_isolated_dio_vme_slave_config;
	import dio_cfg_pkg::*;
	localparam int LIM [4] = '{4, 8, 12, 16};
	localparam logic [3:0] BAD_DEB [3] = '{4'h0, 4'h3, 4'hF};
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  reg_addr = '0;
	logic [15:0] reg_wdata = '0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	bus_cycle_s  bus_cycle;
	logic        irq_source = 1'b0;
	logic [15:0] din_raw = '0;
	logic        board_select;
	logic [7:1]  irq_req;
	logic [15:0] dout_switch;
	int          fails = 0;
	int          check_count = 0;
	int          cycles = 0;

	always #5 clk = ~clk;

	dio_vme_config #(.DEB_CYC_0(4), .DEB_CYC_1(8), .DEB_CYC_2(12), .DEB_CYC_3(16))
	i_dio_vme_config (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_cycle(bus_cycle),
		.irq_source(irq_source), .din_raw(din_raw), .board_select(board_select),
		.irq_req(irq_req), .dout_switch(dout_switch));
	dio_bus_master i_dio_bus_master (.clk(clk), .bus_cycle(bus_cycle));

	function automatic logic [15:0] cfgw(logic sp, logic np, logic [2:0] lv, logic [3:0] db,
		logic ie);
		logic [15:0] w;
		w = '0;
		w[CFG_AM_SPACE] = sp;
		w[CFG_AM_NONPRV] = np;
		w[CFG_IRQ_LSB+:3] = lv;
		w[CFG_DEB_LSB+:4] = db;
		w[CFG_IRQ_EN] = ie;
		return w;
	endfunction
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string nm);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 `CHK(nm, e, reg_rdata)
	endtask
	task automatic sel(input logic [23:0] a, input logic [5:0] m, input logic e);
		i_dio_bus_master.access(a, m);
		#1 `CHK("board_select", e, board_select)
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			summarize();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		rchk(OFS_CONFIG, cfgw(0, 1, 0, 4'h1, 0), "config");
		rchk(OFS_BASE, 16'h0000, "base");
		rchk(OFS_DOUT, 16'h0000, "dout");
		rchk(OFS_DIN, 16'h0000, "din");
		`CHK("switch", 16'h0000, dout_switch)
		$display("reset test done");
		sel(24'h000000, AM_SHORT_SUP, 1'b1);
		sel(24'h0003FE, AM_SHORT_NP, 1'b1);
		sel(24'h000400, AM_SHORT_SUP, 1'b0);
		sel(24'h000000, AM_STD_SUP, 1'b0);
		wr(OFS_BASE, 16'h1205);
		sel(24'h771400, AM_SHORT_SUP, 1'b1);
		sel(24'h770000, AM_SHORT_SUP, 1'b0);
		sel(24'h771C00, AM_SHORT_SUP, 1'b0);
		wr(OFS_CONFIG, cfgw(0, 0, 0, 4'h1, 0));
		sel(24'h001400, AM_SHORT_NP, 1'b0);
		sel(24'h001400, AM_SHORT_SUP, 1'b1);
		wr(OFS_CONFIG, cfgw(1, 1, 0, 4'h1, 0));
		sel(24'h121400, AM_STD_SUP, 1'b1);
		sel(24'h1217FF, AM_STD_NP, 1'b1);
		sel(24'h131400, AM_STD_SUP, 1'b0);
		sel(24'h121400, AM_SHORT_SUP, 1'b0);
		wr(OFS_CONFIG, cfgw(1, 0, 0, 4'h1, 0));
		sel(24'h121400, AM_STD_NP, 1'b0);
		$display("decode test done");
		irq_source <= 1'b1;
		for (int lv = 0; lv < 8; lv++) begin
			wr(OFS_CONFIG, cfgw(0, 1, 3'(lv), 4'h1, 1));
			repeat (3) @(posedge clk);
			#1 `CHK("irq_req", (lv == 0) ? 7'h00 : 7'(1 << (lv - 1)), irq_req)
		end
		irq_source <= 1'b0;
		$display("interrupt test done");
		for (int k = 0; k < 4; k++) begin
			wr(OFS_CONFIG, cfgw(0, 1, 0, 4'(1 << k), 0));
			@(posedge clk);
			din_raw <= 16'hFFFF;
			repeat (LIM[k] / 2) @(posedge clk);
			din_raw <= 16'h0000;
			repeat (2 * LIM[k] + 4) @(posedge clk);
			rchk(OFS_DIN, 16'h0000, "din glitch");
			@(posedge clk);
			din_raw <= 16'h5AC3;
			repeat (2 * LIM[k] + 4) @(posedge clk);
			rchk(OFS_DIN, 16'h5AC3, "din held");
			@(posedge clk);
			din_raw <= 16'h0000;
			repeat (2 * LIM[k] + 4) @(posedge clk);
		end
		foreach (BAD_DEB[i]) begin
			wr(OFS_CONFIG, cfgw(0, 1, 0, BAD_DEB[i], 0));
			@(posedge clk);
			din_raw <= 16'hFFFF;
			repeat (40) @(posedge clk);
			rchk(OFS_DIN, 16'h0000, "din blocked");
			rchk(OFS_STATUS, 16'h0004, "status blocked");
			din_raw <= 16'h0000;
		end
		$display("debounce test done");
		wr(OFS_DOUT, 16'hA5C3);
		rchk(OFS_DOUT, 16'hA5C3, "dout");
		`CHK("switch", 16'hA5C3, dout_switch)
		wr(OFS_DOUT, 16'h5A3C);
		rchk(OFS_DOUT, 16'h5A3C, "dout");
		wr(4'hF, 16'hFFFF);
		rchk(4'hF, 16'h0000, "unmapped");
		$display("output test done");
		summarize();
	end
endmodule // tb_isolated_dio_vme_slave_config
`default_nettype wire

//--- hw/dio_cfg_pkg.sv
// Shared constants and carriers for the isolated digital I/O configuration block.
// Assumes one 100 MHz clock and plain register port access.
package dio_cfg_pkg;

	localparam int CLK_MHZ = 100;
	localparam int CHANNELS = 16;

	// Register offsets on the local port.
	localparam logic [3:0] OFS_CONFIG  = 4'h0;
	localparam logic [3:0] OFS_BASE    = 4'h1;
	localparam logic [3:0] OFS_DIN     = 4'h2;
	localparam logic [3:0] OFS_DOUT    = 4'h3;
	localparam logic [3:0] OFS_STATUS  = 4'h4;

	// Config register fields.
	localparam int CFG_AM_SPACE  = 0;
	localparam int CFG_AM_NONPRV = 1;
	localparam int CFG_IRQ_LSB   = 4;
	localparam int CFG_DEB_LSB   = 8;
	localparam int CFG_IRQ_EN    = 12;

	// Reset values: short space, both short codes, no level, shortest delay.
	localparam logic [5:0] RST_BASE_LOW  = 6'h00;
	localparam logic [7:0] RST_BASE_HIGH = 8'h00;
	localparam logic       RST_AM_SPACE  = 1'b0;
	localparam logic       RST_AM_NONPRV = 1'b1;
	localparam logic [2:0] RST_IRQ_LEVEL = 3'h0;
	localparam logic [3:0] RST_DEBOUNCE  = 4'h1;

	// Address modifier codes.
	localparam logic [5:0] AM_SHORT_SUP  = 6'h2D;
	localparam logic [5:0] AM_SHORT_NP   = 6'h29;
	localparam logic [5:0] AM_STD_SUP    = 6'h3D;
	localparam logic [5:0] AM_STD_NP     = 6'h39;

	// Debounce delays in microseconds, the least figure of each band.
	localparam int DEB_US_0 = 7;
	localparam int DEB_US_1 = 336;
	localparam int DEB_US_2 = 672;
	localparam int DEB_US_3 = 1344;
	localparam int DEB_CYC_0 = DEB_US_0 * CLK_MHZ;
	localparam int DEB_CYC_1 = DEB_US_1 * CLK_MHZ;
	localparam int DEB_CYC_2 = DEB_US_2 * CLK_MHZ;
	localparam int DEB_CYC_3 = DEB_US_3 * CLK_MHZ;
	localparam int DEB_CNT_W = 18;

	typedef struct packed {
		logic [23:0] addr;
		logic [5:0]  am;
		logic        valid;
	} bus_cycle_s;

	typedef struct packed {
		logic        am_space;
		logic        am_nonpriv;
		logic [2:0]  irq_level;
		logic [3:0]  debounce;
		logic        irq_enable;
		logic [5:0]  base_low;
		logic [7:0]  base_high;
	} cfg_s;

endpackage

//--- hw/dio_debounce.sv
// Debounce filter for a bank of input channels sharing one delay.
// Assumes inputs synchronous to clk and a count that is stable between changes.
`timescale 1ns/1ps
`default_nettype none
module dio_debounce #(
	parameter int WIDTH = 16,
	parameter int CW    = 18
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             pass,
	input  wire logic [CW-1:0]    limit,
	input  wire logic [WIDTH-1:0] raw,
	output logic      [WIDTH-1:0] clean
);
	import dio_cfg_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0][CW-1:0] cnt;
		logic [WIDTH-1:0]         val;
	} deb_state_s;

	deb_state_s st;
	deb_state_s next_st;

	always_comb begin
		next_st = st;
		for (int i = 0; i < WIDTH; i++) begin
			if (!pass) begin
				next_st.cnt[i] = '0;
				next_st.val[i] = 1'b0;
			end else if (raw[i] == st.val[i]) begin
				next_st.cnt[i] = '0;
			end else if (st.cnt[i] + CW'(1) >= limit) begin
				next_st.val[i] = raw[i];
				next_st.cnt[i] = '0;
			end else begin
				next_st.cnt[i] = st.cnt[i] + CW'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign clean = st.val;

	property p_short_glitch;
		@(posedge clk) disable iff (srst)
		(pass && raw[0] != st.val[0] && (st.cnt[0] + CW'(1) < limit)) |=> $stable(st.val[0]);
	endproperty
	a_short_glitch: assert property (p_short_glitch) else $error("value moved too early");

	property p_blocked;
		@(posedge clk) disable iff (srst)
		!pass |=> (clean == '0);
	endproperty
	a_blocked: assert property (p_blocked) else $error("input passed while blocked");

endmodule // dio_debounce
`default_nettype wire

//--- hw/dio_vme_config.sv
// Configuration and data path of the isolated 16-in/16-out bus slave board.
// Assumes a bus front end that presents address and modifier, synchronous to clk.
// How it works
// - The board answers only inside its own 1 KB address block.
// - Address lines A10 to A23 are compared with the base selection.
// - Short space compares A10 to A15 only, using the low group.
// - A set selection bit demands a one on its address line.
// - Short space accepts 2DH alone or 2DH and 29H.
// - Standard space accepts 3DH alone or 3DH and 39H.
// - Three-bit interrupt level gives levels 1 to 7, zero means none.
// - Level none asserts no request even with interrupts enabled.
// - Defaults: short base 0000, both short codes, level none.
// - Sixteen input channels are read as one word.
// - Sixteen output channels are driven as one word.
// - Each input has a debounce filter suppressing short glitches.
// - One debounce selection serves all sixteen channels.
// - Debounce select is one-hot among four delays.
// - No selection or several selections block the inputs.
// - Default debounce is the shortest delay.
// - A written output word reads back at once.
// - After reset all inputs and outputs are off.
// - A one turns an output switch on, a zero off.
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dio_vme_config #(
	parameter int CHANNELS = dio_cfg_pkg::CHANNELS,
	parameter int DEB_CYC_0 = dio_cfg_pkg::DEB_CYC_0,
	parameter int DEB_CYC_1 = dio_cfg_pkg::DEB_CYC_1,
	parameter int DEB_CYC_2 = dio_cfg_pkg::DEB_CYC_2,
	parameter int DEB_CYC_3 = dio_cfg_pkg::DEB_CYC_3
) (
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire logic [3:0]             reg_addr,
	input  wire logic [15:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [15:0]            reg_rdata,
	input  wire dio_cfg_pkg::bus_cycle_s bus_cycle,
	input  wire logic                   irq_source,
	input  wire logic [CHANNELS-1:0]    din_raw,
	output logic                        board_select,
	output logic      [7:1]             irq_req,
	output logic      [CHANNELS-1:0]    dout_switch
);
	import dio_cfg_pkg::*;

	localparam int CW = DEB_CNT_W;

	typedef struct packed {
		cfg_s                cfg;
		logic [CHANNELS-1:0] dout;
		logic [15:0]         rdata;
		logic                sel;
		logic [7:1]          irq;
		logic                hit_seen;
	} top_state_s;

	top_state_s st;
	top_state_s next_st;

	logic [CHANNELS-1:0] din_clean;
	logic                deb_pass;
	logic [CW-1:0]       deb_limit;

	function automatic logic onehot4(input logic [3:0] v);
		return (v == 4'h1) || (v == 4'h2) || (v == 4'h4) || (v == 4'h8);
	endfunction

	function automatic logic am_accept(input cfg_s c, input logic [5:0] am);
		logic ok;
		ok = 1'b0;
		if (!c.am_space) begin
			ok = (am == AM_SHORT_SUP) || (c.am_nonpriv && am == AM_SHORT_NP);
		end else begin
			ok = (am == AM_STD_SUP) || (c.am_nonpriv && am == AM_STD_NP);
		end
		return ok;
	endfunction

	function automatic logic addr_match(input cfg_s c, input logic [23:0] a);
		logic ok;
		ok = (a[15:10] == c.base_low);
		if (c.am_space) begin
			ok = ok && (a[23:16] == c.base_high);
		end
		return ok;
	endfunction

	always_comb begin
		deb_pass = onehot4(st.cfg.debounce);
		deb_limit = CW'(DEB_CYC_0);
		if (st.cfg.debounce[1]) begin
			deb_limit = CW'(DEB_CYC_1);
		end else if (st.cfg.debounce[2]) begin
			deb_limit = CW'(DEB_CYC_2);
		end else if (st.cfg.debounce[3]) begin
			deb_limit = CW'(DEB_CYC_3);
		end
	end

	dio_debounce #(
		.WIDTH (CHANNELS),
		.CW    (CW)
	) u_deb (
		.clk   (clk),
		.srst  (srst),
		.pass  (deb_pass),
		.limit (deb_limit),
		.raw   (din_raw),
		.clean (din_clean)
	);

	always_comb begin
		next_st = st;
		next_st.rdata = 16'h0000;
		next_st.sel = bus_cycle.valid && am_accept(st.cfg, bus_cycle.am)
			&& addr_match(st.cfg, bus_cycle.addr);
		next_st.hit_seen = next_st.sel;
		next_st.irq = 7'h00;
		if (irq_source && st.cfg.irq_enable && st.cfg.irq_level != 3'h0) begin
			next_st.irq[st.cfg.irq_level] = 1'b1;
		end
		if (reg_wr) begin
			if (reg_addr == OFS_CONFIG) begin
				next_st.cfg.am_space = reg_wdata[CFG_AM_SPACE];
				next_st.cfg.am_nonpriv = reg_wdata[CFG_AM_NONPRV];
				next_st.cfg.irq_level = reg_wdata[CFG_IRQ_LSB +: 3];
				next_st.cfg.debounce = reg_wdata[CFG_DEB_LSB +: 4];
				next_st.cfg.irq_enable = reg_wdata[CFG_IRQ_EN];
			end else if (reg_addr == OFS_BASE) begin
				next_st.cfg.base_low = reg_wdata[5:0];
				next_st.cfg.base_high = reg_wdata[15:8];
			end else if (reg_addr == OFS_DOUT) begin
				next_st.dout = reg_wdata[CHANNELS-1:0];
			end
		end
		if (reg_rd) begin
			if (reg_addr == OFS_CONFIG) begin
				next_st.rdata[CFG_AM_SPACE] = st.cfg.am_space;
				next_st.rdata[CFG_AM_NONPRV] = st.cfg.am_nonpriv;
				next_st.rdata[CFG_IRQ_LSB +: 3] = st.cfg.irq_level;
				next_st.rdata[CFG_DEB_LSB +: 4] = st.cfg.debounce;
				next_st.rdata[CFG_IRQ_EN] = st.cfg.irq_enable;
			end else if (reg_addr == OFS_BASE) begin
				next_st.rdata = {st.cfg.base_high, 2'b00, st.cfg.base_low};
			end else if (reg_addr == OFS_DIN) begin
				next_st.rdata = din_clean;
			end else if (reg_addr == OFS_DOUT) begin
				next_st.rdata = st.dout;
			end else if (reg_addr == OFS_STATUS) begin
				next_st.rdata = {13'h0000, !deb_pass, st.hit_seen, |st.irq};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
			st.cfg.am_space <= RST_AM_SPACE;
			st.cfg.am_nonpriv <= RST_AM_NONPRV;
			st.cfg.irq_level <= RST_IRQ_LEVEL;
			st.cfg.debounce <= RST_DEBOUNCE;
			st.cfg.base_low <= RST_BASE_LOW;
			st.cfg.base_high <= RST_BASE_HIGH;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign board_select = st.sel;
	assign irq_req = st.irq;
	assign dout_switch = st.dout;

	property p_readback;
		@(posedge clk) disable iff (srst)
		(reg_wr && reg_addr == OFS_DOUT) ##1 (reg_rd && reg_addr == OFS_DOUT)
			|=> (reg_rdata == $past(reg_wdata, 2));
	endproperty
	a_readback: assert property (p_readback) else $error("output readback wrong");

	property p_dout;
		@(posedge clk) disable iff (srst)
		(reg_wr && reg_addr == OFS_DOUT) |=> (dout_switch == $past(reg_wdata));
	endproperty
	a_dout: assert property (p_dout) else $error("output word not applied");

	property p_no_level;
		@(posedge clk) disable iff (srst)
		(st.cfg.irq_level == 3'h0) |=> (irq_req == 7'h00);
	endproperty
	a_no_level: assert property (p_no_level) else $error("request with level none");

	property p_level;
		@(posedge clk) disable iff (srst)
		(irq_source && st.cfg.irq_enable && st.cfg.irq_level == 3'h3) |=> irq_req == 7'h04;
	endproperty
	a_level: assert property (p_level) else $error("wrong request level");

	property p_short_np;
		@(posedge clk) disable iff (srst)
		(bus_cycle.valid && !st.cfg.am_space && !st.cfg.am_nonpriv
			&& bus_cycle.am == AM_SHORT_NP) |=> !board_select;
	endproperty
	a_short_np: assert property (p_short_np) else $error("29H accepted when disabled");

	property p_std_only;
		@(posedge clk) disable iff (srst)
		(st.cfg.am_space && bus_cycle.am[5:4] == 2'h2) |=> !board_select;
	endproperty
	a_std_only: assert property (p_std_only) else $error("short code in standard space");

	property p_block;
		@(posedge clk) disable iff (srst)
		(bus_cycle.addr[15:10] != st.cfg.base_low) |=> !board_select;
	endproperty
	a_block: assert property (p_block) else $error("select outside block");

	property p_high;
		@(posedge clk) disable iff (srst)
		(st.cfg.am_space && bus_cycle.addr[23:16] != st.cfg.base_high) |=> !board_select;
	endproperty
	a_high: assert property (p_high) else $error("upper lines ignored");

	c_select: cover property (@(posedge clk) disable iff (srst) board_select);
	c_irq: cover property (@(posedge clk) disable iff (srst) |irq_req);
	c_blocked: cover property (@(posedge clk) disable iff (srst) !deb_pass);

endmodule // dio_vme_config
`default_nettype wire
